// *** spi_eeprom_protect_ctrl_pkg.sv ***
// constants, types and command codes of the spi eeprom protect block
`default_nettype none
package spi_eeprom_protect_ctrl_pkg;
    // opcodes, msb first on the wire
    localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] CMD_SET_FLAG = 8'h00;
    localparam logic [7:0] CMD_CLEAR_LATCH_FLAG = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h02;

    // status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic protect_pin_enable;
        logic user_flag;
        logic [1:0] fixed;
        logic region_guard_hi;
        logic region_guard_lo;
        logic write_latch_bit;
        logic write_busy;
    } status_t;
    localparam logic [1:0] FIXED_ONES = 2'h3;

    // array geometry, 8k by 8
    localparam int ADDR_W = 13;
    localparam int ARRAY_BYTES = 8192;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam logic [ADDR_W-1:0] GUARD_QUARTER = 13'h1800;
    localparam logic [ADDR_W-1:0] GUARD_HALF = 13'h1000;
    localparam logic [ADDR_W-1:0] GUARD_ALL = 13'h0000;
    localparam logic [1:0] GUARD_NONE = 2'h0;

    // frame bit and byte counters
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BYTE_OP = 3'h0;
    localparam logic [2:0] BYTE_ADDR_HI = 3'h1;
    localparam logic [2:0] BYTE_ADDR_LO = 3'h2;
    localparam logic [2:0] BYTE_DATA = 3'h3;
    localparam logic [2:0] BYTE_SAT = 3'h4;

    // timing, both are least times and round up
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned HOLD_TIME_MS = 200;
    localparam int unsigned WRITE_TIME_US = 5000;
    localparam int unsigned HOLD_CYC_DEF =
        (HOLD_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYC_DEF =
        (WRITE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 23;

    typedef enum logic [2:0] {
        ACT_NONE = 3'b000,
        ACT_SET_WL = 3'b001,
        ACT_CLEAR = 3'b010,
        ACT_SET_FLAG = 3'b011,
        ACT_WR_STAT = 3'b100,
        ACT_WR_ARRAY = 3'b101
    } act_t;

    typedef enum logic [1:0] {
        NV_IDLE = 2'b00,
        NV_COPY = 2'b01,
        NV_WAIT = 2'b10
    } nv_state_t;
endpackage
`default_nettype wire

// *** spi_eeprom_protect_ctrl.sv ***
// spi slave command, protection and supply reset logic of the eeprom
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - serial output changes on the falling serial clock edge during reads.
// - opcode, address and data bits are sampled on rising serial clock.
// - chip select high floats serial output; busy write keeps running.
// - no command is accepted before a chip select high-to-low after reset.
// - protect pin low with pin enable set refuses status writes.
// - a status write already started finishes despite the protect pin.
// - protect pin is ignored while pin enable bit is zero.
// - supply reset active while supply low, released after hold time.
// - first eight bits of a frame load the instruction register.
// - all bytes travel most significant bit first both ways.
// - stopped serial clock just pauses; state holds until clocks resume.
// - set latch sets, clear latch clears; reset and write end clear.
// - status register readable any time, also during a busy write.
// - status holds pin enable, flag, ones, guard hi/lo, latch, busy.
// - busy bit is read-only, one only while a nonvolatile write runs.
// - guarded array region reads normally but refuses writes.
// - guard codes protect none, top quarter, top half, whole array.
// - status bits 5 and 4 always read as ones.
// - opcodes 06 set latch, 00 set flag, 04 clear latch and flag.
// - opcodes 03 read and 02 write, starting at the following address.
// - opcodes 05 read status, 01 write status guard, enable and flag.
// - reads stream bytes with address increment, wrapping to zero.
// - set latch counts only when chip select rises after eight bits.
// - writes start only if chip select rises on a byte boundary.
// - page write address wraps within its page, overwriting buffer.
module spi_eeprom_protect_ctrl
    import spi_eeprom_protect_ctrl_pkg::*;
#(
    parameter int unsigned HOLD_CYC =
        spi_eeprom_protect_ctrl_pkg::HOLD_CYC_DEF,
    parameter int unsigned WRITE_CYC =
        spi_eeprom_protect_ctrl_pkg::WRITE_CYC_DEF
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic i_supply_ok,
    output logic o_so,
    output logic o_so_oe_n,
    output logic o_supply_rst
);
    import spi_eeprom_protect_ctrl_pkg::*;

    logic [7:0] mem [0:ARRAY_BYTES-1];
    logic [7:0] page_buf [0:PAGE_BYTES-1];

    // serial clock domain
    logic [2:0] bit_reg;
    logic [2:0] byte_reg;
    logic [6:0] shift_reg;
    logic [7:0] op_reg;
    logic [15:0] addr_reg;
    logic [7:0] tx_reg;
    logic [PAGE_BYTES-1:0] valid_reg;
    act_t act_reg;
    status_t stat_data_reg;
    logic tog_reg;
    status_t stat_meta_reg;
    status_t stat_sync_reg;

    // system clock domain
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic wp_meta_reg;
    logic wp_sync_reg;
    logic sup_meta_reg;
    logic sup_sync_reg;
    logic armed_reg;
    logic seen_tog_reg;
    logic wel_reg;
    logic flag_reg;
    logic pin_en_reg;
    logic [1:0] guard_reg;
    logic [ADDR_W-PAGE_W-1:0] page_reg;
    nv_state_t nv_state_reg;
    nv_state_t nv_state_next;
    logic [PAGE_W-1:0] idx_reg;
    logic [CNT_W-1:0] wait_cnt_reg;
    logic [CNT_W-1:0] hold_cnt_reg;

    // frame decode on the serial side
    logic [7:0] rx_byte;
    logic byte_done;
    logic first_edge;
    logic [2:0] bit_next;
    logic [2:0] byte_next;
    logic [7:0] cur_op;
    logic done_op;
    logic done_hi;
    logic done_lo;
    logic done_data;
    logic busy_s;
    logic is_read;
    logic is_cmd_read_status_alt;
    logic is_write;
    logic buf_we;
    logic [PAGE_W-1:0] page_off;
    logic [PAGE_W-1:0] page_off_inc;
    logic [15:0] addr_rd;
    logic drive_en;
    act_t act_next;

    assign rx_byte = {shift_reg, i_si};
    assign byte_done = (bit_reg == BIT_LAST);
    assign first_edge = (bit_reg == 3'h0) && (byte_reg == BYTE_OP);
    assign bit_next = 3'(bit_reg + 3'h1);
    assign byte_next = (byte_done && byte_reg != BYTE_SAT) ?
        3'(byte_reg + 3'h1) : byte_reg;
    assign done_op = byte_done && (byte_reg == BYTE_OP);
    assign done_hi = byte_done && (byte_reg == BYTE_ADDR_HI);
    assign done_lo = byte_done && (byte_reg == BYTE_ADDR_LO);
    assign done_data = byte_done && (byte_reg >= BYTE_DATA);
    assign cur_op = done_op ? rx_byte : op_reg;
    assign busy_s = stat_sync_reg.write_busy;
    assign is_read = (op_reg == CMD_READ);
    assign is_cmd_read_status_alt = (cur_op == CMD_READ_STATUS);
    assign is_write = (op_reg == CMD_WRITE);
    // the buffer stays frozen while the copy into the array runs
    assign buf_we = done_data && is_write && !busy_s;
    assign page_off = addr_reg[PAGE_W-1:0];
    assign page_off_inc = PAGE_W'(page_off + 1'b1);
    assign addr_rd = done_lo ? {addr_reg[15:8], rx_byte} : addr_reg;
    assign drive_en = armed_reg &&
        ((is_read && byte_reg >= BYTE_DATA) ||
         (op_reg == CMD_READ_STATUS && byte_reg >= BYTE_ADDR_HI));

    // action that takes effect if chip select rises right after this edge
    assign act_next =
        !byte_done ? ACT_NONE :
        (done_op && rx_byte == CMD_SET_WRITE_LATCH) ? ACT_SET_WL :
        (done_op && rx_byte == CMD_CLEAR_LATCH_FLAG) ? ACT_CLEAR :
        (done_op && rx_byte == CMD_SET_FLAG) ? ACT_SET_FLAG :
        (done_hi && op_reg == CMD_WRITE_STATUS) ? ACT_WR_STAT :
        (done_data && is_write) ? ACT_WR_ARRAY : ACT_NONE;

    // frame counters restart whenever chip select is high
    always_ff @(posedge i_sck or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            bit_reg <= 3'h0;
            byte_reg <= BYTE_OP;
            shift_reg <= 7'h00;
        end
        else
        begin
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            shift_reg <= rx_byte[6:0];
        end
    end

    // state that must outlive the frame for the commit at chip select rise
    always_ff @(posedge i_sck or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            op_reg <= 8'hff;
            addr_reg <= 16'h0000;
            tx_reg <= 8'h00;
            valid_reg <= '0;
            act_reg <= ACT_NONE;
            stat_data_reg <= '0;
            tog_reg <= 1'b0;
            stat_meta_reg <= '0;
            stat_sync_reg <= '0;
        end
        else if (!i_cs_n)
        begin
            stat_meta_reg <= {pin_en_reg, flag_reg, FIXED_ONES,
                guard_reg, wel_reg, (nv_state_reg != NV_IDLE)};
            stat_sync_reg <= stat_meta_reg;
            act_reg <= act_next;
            if (first_edge)
                tog_reg <= ~tog_reg;
            if (done_op)
                op_reg <= rx_byte;
            if (done_op && rx_byte == CMD_WRITE && !busy_s)
                valid_reg <= '0;
            if (done_hi)
            begin
                addr_reg[15:8] <= rx_byte;
                if (op_reg == CMD_WRITE_STATUS)
                    stat_data_reg <= status_t'(rx_byte);
            end
            if (done_lo && !is_read)
                addr_reg[7:0] <= rx_byte;
            if ((done_lo || done_data) && is_read)
            begin
                tx_reg <= mem[addr_rd[ADDR_W-1:0]];
                addr_reg <= {3'h0, ADDR_W'(addr_rd[ADDR_W-1:0] + 1'b1)};
            end
            else if (byte_done && is_cmd_read_status_alt)
                tx_reg <= stat_sync_reg;
            if (buf_we)
            begin
                valid_reg[page_off] <= 1'b1;
                addr_reg[PAGE_W-1:0] <= page_off_inc;
            end
        end
    end

    always_ff @(posedge i_sck)
    begin
        if (!i_cs_n && buf_we)
            page_buf[page_off] <= rx_byte;
    end

    // output side, floats whenever chip select is high
    always_ff @(negedge i_sck or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            o_so <= 1'b0;
            o_so_oe_n <= 1'b1;
        end
        else
        begin
            o_so <= tx_reg[3'(BIT_LAST - bit_reg)];
            o_so_oe_n <= ~drive_en;
        end
    end

    // system clock side: commit, nonvolatile write timing, supply reset
    logic cs_rise;
    logic commit;
    logic pin_locked;
    logic stat_ok;
    logic array_ok;
    logic nv_done;
    logic copy_last;
    logic guarded;
    logic mem_we;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] guard_base;
    status_t sd;

    assign cs_rise = cs_sync_reg && !cs_prev_reg;
    // act and toggle are still from chip select rise onward until an edge
    assign commit = cs_rise && armed_reg && (tog_reg != seen_tog_reg);
    assign pin_locked = pin_en_reg && !wp_sync_reg;
    assign stat_ok = wel_reg && (nv_state_reg == NV_IDLE) && !pin_locked;
    assign array_ok = wel_reg && (nv_state_reg == NV_IDLE);
    assign nv_done = (nv_state_reg == NV_WAIT) &&
        (wait_cnt_reg == CNT_W'(WRITE_CYC - 1));
    assign copy_last = (idx_reg == PAGE_W'(PAGE_BYTES - 1));
    assign sd = stat_data_reg;
    assign wr_addr = {page_reg, idx_reg};
    assign guard_base = (guard_reg == 2'h1) ? GUARD_QUARTER :
        (guard_reg == 2'h2) ? GUARD_HALF : GUARD_ALL;
    assign guarded = (guard_reg != GUARD_NONE) && (wr_addr >= guard_base);
    assign mem_we = (nv_state_reg == NV_COPY) && valid_reg[idx_reg] &&
        !guarded;

    always_comb
    begin
        nv_state_next = nv_state_reg;
        unique case (nv_state_reg)
            NV_IDLE:
            begin
                if (commit && act_reg == ACT_WR_STAT && stat_ok)
                    nv_state_next = NV_WAIT;
                else if (commit && act_reg == ACT_WR_ARRAY && array_ok)
                    nv_state_next = NV_COPY;
            end
            NV_COPY:
            begin
                if (copy_last)
                    nv_state_next = NV_WAIT;
            end
            NV_WAIT:
            begin
                if (nv_done)
                    nv_state_next = NV_IDLE;
            end
            default:
                nv_state_next = NV_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cs_meta_reg <= 1'b0;
            cs_sync_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
            wp_meta_reg <= 1'b0;
            wp_sync_reg <= 1'b0;
            sup_meta_reg <= 1'b0;
            sup_sync_reg <= 1'b0;
            armed_reg <= 1'b0;
            seen_tog_reg <= 1'b0;
            nv_state_reg <= NV_IDLE;
            idx_reg <= '0;
            wait_cnt_reg <= '0;
            page_reg <= '0;
        end
        else
        begin
            cs_meta_reg <= i_cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            wp_meta_reg <= i_wp_n;
            wp_sync_reg <= wp_meta_reg;
            sup_meta_reg <= i_supply_ok;
            sup_sync_reg <= sup_meta_reg;
            armed_reg <= armed_reg | cs_sync_reg;
            if (cs_rise)
                seen_tog_reg <= tog_reg;
            nv_state_reg <= nv_state_next;
            idx_reg <= (nv_state_reg == NV_COPY) ?
                PAGE_W'(idx_reg + 1'b1) : '0;
            wait_cnt_reg <= (nv_state_reg == NV_WAIT) ?
                CNT_W'(wait_cnt_reg + 1'b1) : '0;
            if (nv_state_reg == NV_IDLE)
                page_reg <= addr_reg[ADDR_W-1:PAGE_W];
        end
    end

    // latch and flag: a command at the same edge as write end wins
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wel_reg <= 1'b0;
            flag_reg <= 1'b0;
            pin_en_reg <= 1'b0;
            guard_reg <= GUARD_NONE;
        end
        else
        begin
            if (nv_done)
                wel_reg <= 1'b0;
            if (commit && act_reg == ACT_SET_WL)
                wel_reg <= 1'b1;
            if (commit && act_reg == ACT_CLEAR)
            begin
                wel_reg <= 1'b0;
                flag_reg <= 1'b0;
            end
            if (commit && act_reg == ACT_SET_FLAG)
                flag_reg <= 1'b1;
            if (commit && act_reg == ACT_WR_STAT && stat_ok)
            begin
                pin_en_reg <= sd.protect_pin_enable;
                flag_reg <= sd.user_flag;
                guard_reg <= {sd.region_guard_hi, sd.region_guard_lo};
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (mem_we)
            mem[wr_addr] <= page_buf[idx_reg];
    end

    // the hold time restarts on every dip below the sense level
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_supply_rst <= 1'b1;
            hold_cnt_reg <= '0;
        end
        else if (!sup_sync_reg)
        begin
            o_supply_rst <= 1'b1;
            hold_cnt_reg <= '0;
        end
        else if (o_supply_rst)
        begin
            if (hold_cnt_reg == CNT_W'(HOLD_CYC - 1))
                o_supply_rst <= 1'b0;
            else
                hold_cnt_reg <= CNT_W'(hold_cnt_reg + 1'b1);
        end
    end

    // checks on the serial side
    property p_op_load;
        @(posedge i_sck) disable iff (i_cs_n || i_sys_rst)
        done_op |=> op_reg == $past(rx_byte);
    endproperty
    a_op_load: assert property (p_op_load)
        else $error("instruction register not loaded");

    property p_so_bit;
        @(posedge i_sck) disable iff (i_cs_n || i_sys_rst)
        !o_so_oe_n |-> o_so == tx_reg[3'(BIT_LAST - bit_reg)];
    endproperty
    a_so_bit: assert property (p_so_bit)
        else $error("serial output bit out of order");

    property p_page_wrap;
        @(posedge i_sck) disable iff (i_cs_n || i_sys_rst)
        buf_we |=> addr_reg[15:PAGE_W] == $past(addr_reg[15:PAGE_W]);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page write left its page");

    property p_read_inc;
        @(posedge i_sck) disable iff (i_cs_n || i_sys_rst)
        done_data && is_read |=>
            addr_reg[ADDR_W-1:0] == ADDR_W'($past(addr_reg[ADDR_W-1:0]) + 1);
    endproperty
    a_read_inc: assert property (p_read_inc)
        else $error("read address did not advance");

    // checks on the system side
    logic busy_w;
    assign busy_w = (nv_state_reg != NV_IDLE);

    sequence s_stat_commit;
        commit && act_reg == ACT_WR_STAT && wel_reg &&
            nv_state_reg == NV_IDLE;
    endsequence

    property p_pin_lock;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_stat_commit ##0 pin_locked |=>
            $stable(guard_reg) && $stable(pin_en_reg) && !busy_w;
    endproperty
    a_pin_lock: assert property (p_pin_lock)
        else $error("status write accepted while pin locked");

    property p_pin_free;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_stat_commit ##0 !pin_en_reg |=>
            guard_reg == {$past(sd.region_guard_hi),
                $past(sd.region_guard_lo)} && busy_w;
    endproperty
    a_pin_free: assert property (p_pin_free)
        else $error("status write refused with pin disabled");

    property p_busy_end;
        @(posedge i_clk) disable iff (i_sys_rst)
        $fell(busy_w) |-> !wel_reg || $past(commit);
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("latch not cleared at write end");

    property p_set_wl;
        @(posedge i_clk) disable iff (i_sys_rst)
        commit && act_reg == ACT_SET_WL |=> wel_reg;
    endproperty
    a_set_wl: assert property (p_set_wl)
        else $error("set latch command lost");

    property p_unarmed;
        @(posedge i_clk) disable iff (i_sys_rst)
        !armed_reg |=> $stable(wel_reg) && $stable(flag_reg);
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("command taken before chip select fall");

    property p_guard;
        @(posedge i_clk) disable iff (i_sys_rst)
        mem_we |-> guard_reg == GUARD_NONE ||
            (guard_reg == 2'h1 && wr_addr < GUARD_QUARTER) ||
            (guard_reg == 2'h2 && wr_addr < GUARD_HALF);
    endproperty
    a_guard: assert property (p_guard)
        else $error("write into guarded region");

    property p_wait_len;
        @(posedge i_clk) disable iff (i_sys_rst)
        nv_state_reg == NV_WAIT |-> wait_cnt_reg < CNT_W'(WRITE_CYC);
    endproperty
    a_wait_len: assert property (p_wait_len)
        else $error("write cycle overran its duration");

    property p_sup_low;
        @(posedge i_clk) disable iff (i_sys_rst)
        !sup_sync_reg |=> o_supply_rst && hold_cnt_reg == '0;
    endproperty
    a_sup_low: assert property (p_sup_low)
        else $error("supply reset not active while supply low");

    property p_sup_rel;
        @(posedge i_clk) disable iff (i_sys_rst)
        $fell(o_supply_rst) |->
            $past(hold_cnt_reg) == CNT_W'(HOLD_CYC - 1);
    endproperty
    a_sup_rel: assert property (p_sup_rel)
        else $error("supply reset released early");

    property p_cs_float;
        @(posedge i_clk) disable iff (i_sys_rst)
        cs_sync_reg |-> o_so_oe_n;
    endproperty
    a_cs_float: assert property (p_cs_float)
        else $error("output driven while deselected");
endmodule
`default_nettype wire

// *** spi_master_model.sv ***
// spi bus master model for the eeprom block
`timescale 1ns/1ns
`default_nettype none
module spi_master_model
(
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    logic stall = 1'b0;
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b0;
        o_si = 1'b0;
        // a clean rising edge clears the output stage at start
        #5 o_cs_n = 1'b1;
    end
    // sck idles low outside frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            o_si = tx[i];
            #40 o_sck = 1'b1;
            rx[i] = i_so;
            #40 o_sck = 1'b0;
            if (stall && i == 4)
                #900;
        end
    endtask
    // odd offset keeps sck off the system clock edges
    task automatic sel();
        #7 o_cs_n = 1'b0;
        #40;
    endtask
    // si turns over once released, cs held low till here
    task automatic desel();
        #40 o_cs_n = 1'b1;
        o_si = ~o_si;
        #400;
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the spi eeprom protect block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import spi_eeprom_protect_ctrl_pkg::*;
    localparam int unsigned HOLD = 20;
    logic i_clk, i_sys_rst, i_wp_n, i_supply_ok;
    wire logic sck, cs_n, si, so, oe_n, srst;
    int failures = 0;
    int n_checks = 0;
    logic [7:0] rx, r0, r1, b1, b2, b3, d;
    // a released line reads inverted, so only driven bits can match
    spi_master_model m (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
        .i_so(so ^ oe_n));
    // write time long enough that the first poll still sees busy
    spi_eeprom_protect_ctrl #(.HOLD_CYC(HOLD), .WRITE_CYC(40)) i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n),
        .i_supply_ok(i_supply_ok), .o_so(so), .o_so_oe_n(oe_n),
        .o_supply_rst(srst));
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    function automatic logic [7:0] st(logic [7:0] nv, logic wl);
        return {nv[7:6], 2'b11, nv[3:2], wl, 1'b0};
    endfunction
    task automatic stop_test();
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        m.sel();
        m.xfer(op, rx);
        m.desel();
    endtask
    task automatic get_st();
        m.sel();
        m.xfer(CMD_READ_STATUS, rx);
        m.xfer(8'h00, rx);
        m.desel();
        chk1(oe_n, 1'b1);
    endtask
    // polling is the only completion handshake the pins offer
    task automatic wait_idle();
        int k;
        k = 0;
        get_st();
        chk1(rx[0], 1'b1);
        while (rx[0] !== 1'b0 && k < 40)
        begin
            get_st();
            k++;
        end
        if (k == 40)
            failures++;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] v, int n);
        cmd(CMD_SET_WRITE_LATCH);
        m.sel();
        m.xfer(CMD_WRITE, rx);
        m.xfer(a[15:8], rx);
        m.xfer(a[7:0], rx);
        for (int i = 0; i < n; i++)
            m.xfer(v + 8'(i * 8'h5b), rx);
        m.desel();
        wait_idle();
        chk1(rx[1], 1'b0);
    endtask
    task automatic rd(input logic [15:0] a);
        m.sel();
        m.xfer(CMD_READ, rx);
        m.xfer(a[15:8], rx);
        m.xfer(a[7:0], rx);
        m.xfer(8'h00, r0);
        m.xfer(8'h00, r1);
        m.desel();
    endtask
    task automatic wst(input logic [7:0] v);
        cmd(CMD_SET_WRITE_LATCH);
        m.sel();
        m.xfer(CMD_WRITE_STATUS, rx);
        m.xfer(v, rx);
        m.desel();
    endtask
    initial
    begin
        #2000000;
        failures++;
        stop_test();
    end
    initial
    begin
        i_sys_rst = 1'b1;
        i_wp_n = 1'b1;
        i_supply_ok = 1'b1;
        void'($urandom(84189));
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (HOLD - 2) @(negedge i_clk);
        chk1(srst, 1'b1);
        repeat (8) @(negedge i_clk);
        chk1(srst, 1'b0);
        @(posedge i_clk) i_supply_ok <= 1'b0;
        repeat (4) @(negedge i_clk);
        chk1(srst, 1'b1);
        @(posedge i_clk) i_supply_ok <= 1'b1;
        repeat (HOLD - 1) @(negedge i_clk);
        chk1(srst, 1'b1);
        repeat (6) @(negedge i_clk);
        chk1(srst, 1'b0);
        get_st();
        chk(rx, 8'h30);
        cmd(CMD_SET_FLAG);
        get_st();
        chk(rx, 8'h70);
        cmd(CMD_CLEAR_LATCH_FLAG);
        m.sel();
        m.xfer(CMD_SET_WRITE_LATCH, rx);
        m.xfer(8'h00, rx);
        m.desel();
        get_st();
        chk(rx, 8'h30);
        m.sel();
        m.xfer(8'hff, rx);
        m.xfer(8'h00, rx);
        chk1(oe_n, 1'b1);
        m.desel();
        b1 = 8'($urandom);
        b3 = 8'($urandom);
        wr(16'h1fff, b1, 2);
        wr(16'h0000, b3, 1);
        m.stall = 1'b1;
        rd(16'h1fff);
        m.stall = 1'b0;
        chk(r0, b1);
        chk(r1, b3);
        rd(16'h1fe0);
        chk(r0, b1 + 8'h5b);
        d = {2'b10, 2'b11, 2'($urandom), 2'b00};
        @(posedge i_clk) i_wp_n <= 1'b0;
        wst(d);
        wait_idle();
        chk(rx, st(d, 1'b0));
        wst(8'h30);
        get_st();
        chk(rx, st(d, 1'b1));
        @(posedge i_clk) i_wp_n <= 1'b1;
        wst(8'hb4);
        @(posedge i_clk) i_wp_n <= 1'b0;
        wait_idle();
        chk(rx, 8'hb4);
        b2 = 8'($urandom);
        wr(16'h1fff, ~b1, 1);
        wr(16'h17ff, b2, 1);
        rd(16'h1fff);
        chk(r0, b1);
        rd(16'h17ff);
        chk(r0, b2);
        stop_test();
    end
endmodule
`default_nettype wire
